// *** core_sysreg.v ***
// Function
// - current priority level is 3 bits, 000 highest, 111 lowest; gates preemption
// - on preemption the previous priority level is saved in nested control
// - flags pushed on interrupt entry, restored on return, up to seven deep
// - status flags hold eight bits, all zero after reset
// - carry is carry out of bit 7 or bit 15 for arithmetic ops
// - set, clear and invert carry touch no other flag
// - zero flag set when accumulator result is zero
// - sign flag copies bit 7 or bit 15 of the result
// - overflow set when signed result leaves its range
// - bcd kind flag records add versus subtract for decimal adjust
// - half carry records carry or borrow at bit 3; decimal adjust uses it
// - flag bit 0 selects data pointers for data, set and cleared by instructions
// - register file seen as 32 blocks of eight, 5-bit block number
// - single mode maps r0-r7 to the even block at or below the given number, r8-r15 to the odd block after it
// - twin mode maps r0-r7 by pointer zero, r8-r15 by pointer one
// - pointer zero: block in 7:3, mode in bit 2, bits 1:0 read zero
// - single set clears mode bit; twin sets set it and load a block
// - group d only reachable as working registers or via stack pointers
// - page pointer selects one of 64 pages of 16 into group f
// - page pointer not saved on interrupt entry
// - page number in bits 7:2, bits 1:0 forced zero
`timescale 1ns/1ps
`default_nettype none
`include "core_sysreg_regs.vh"
module core_sysreg #(
    parameter PAGE_COUNT = 64
) (
    // clock and reset
    input  wire        clock,
    input  wire        reset_n,
    // register access port
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_addr_err,
    // alu result
    input  wire [3:0]  alu_op,
    input  wire        alu_word,
    input  wire [15:0] alu_a,
    input  wire [15:0] alu_b,
    input  wire [15:0] alu_result,
    input  wire        alu_carry,
    // pointer instructions
    input  wire        set_single_pointer_instr,
    input  wire        set_low_twin_pointer_instr,
    input  wire        set_high_twin_pointer_instr,
    input  wire        set_page_instr,
    input  wire [7:0]  instr_operand,
    // interrupt events
    input  wire        int_request,
    input  wire [2:0]  int_level,
    input  wire        int_return,
    // working register resolution
    input  wire [3:0]  work_reg_index,
    output reg  [7:0]  work_reg_addr,
    output reg  [5:0]  page_number,
    output reg         data_space_select_flag,
    output reg  [2:0]  current_priority,
    output reg         int_accept,
    output reg         stack_overflow
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg  [7:0] status_flags;
    reg  [4:0] block_zero;
    reg  [4:0] block_one;
    reg        twin_mode_select;
    reg  [5:0] page_reg;
    reg  [2:0] cpl_reg;
    reg  [2:0] nested_interrupt_control;
    reg  [2:0] depth_reg;
    reg        pop_pending;
    wire [10:0] stack_rd;
    reg  [7:0] flags_next;

    wire [7:0] wptr_zero_view = {block_zero, twin_mode_select, 2'b00};
    wire [7:0] wptr_one_view  = {block_one, twin_mode_select, 2'b00};
    wire [7:0] page_view      = {page_reg, 2'b00};

    wire preempt = int_request && (int_level < cpl_reg)
                   && (depth_reg < `STACK_DEPTH);
    wire push    = preempt;
    wire pop     = int_return && (depth_reg != 3'h0);

    // ---------------------------------------------------------------
    // flag computation
    // ---------------------------------------------------------------
    function signed_ovf;
        input        word;
        input [15:0] a;
        input [15:0] b;
        input [15:0] r;
        input        sub;
        reg          sa, sb, sr;
        begin
            sa = word ? a[15] : a[7];
            sb = (word ? b[15] : b[7]) ^ sub;
            sr = word ? r[15] : r[7];
            signed_ovf = (sa == sb) && (sr != sa);
        end
    endfunction

    function top_bit;
        input        word;
        input [15:0] r;
        begin
            top_bit = word ? r[15] : r[7];
        end
    endfunction

    always @* begin
        flags_next = status_flags;
        case (alu_op)
            `OP_ADD, `OP_SUB: begin
                flags_next[`FLAG_CARRY]    = alu_carry;
                flags_next[`FLAG_ZERO]     = alu_word ? (alu_result == 16'h0000)
                                                      : (alu_result[7:0] == 8'h00);
                flags_next[`FLAG_SIGN]     = top_bit(alu_word, alu_result);
                flags_next[`FLAG_OVERFLOW] = signed_ovf(alu_word, alu_a, alu_b,
                                                        alu_result, alu_op == `OP_SUB);
                flags_next[`FLAG_BCD_KIND] = (alu_op == `OP_SUB);
                flags_next[`FLAG_HALF]     = alu_a[4] ^ alu_b[4] ^ alu_result[4];
            end
            `OP_SHIFT, `OP_DA, `OP_MULDIV: begin
                flags_next[`FLAG_CARRY]    = alu_carry;
                flags_next[`FLAG_ZERO]     = alu_word ? (alu_result == 16'h0000)
                                                      : (alu_result[7:0] == 8'h00);
                flags_next[`FLAG_SIGN]     = top_bit(alu_word, alu_result);
                flags_next[`FLAG_OVERFLOW] = top_bit(alu_word, alu_result)
                                             ^ top_bit(alu_word, alu_a);
            end
            `OP_LOGIC, `OP_INCDEC: begin
                flags_next[`FLAG_ZERO]     = alu_word ? (alu_result == 16'h0000)
                                                      : (alu_result[7:0] == 8'h00);
                flags_next[`FLAG_SIGN]     = top_bit(alu_word, alu_result);
                flags_next[`FLAG_OVERFLOW] = (alu_op == `OP_INCDEC) &&
                                             signed_ovf(alu_word, alu_a, 16'h0000,
                                                        alu_result, 1'b0);
            end
            `OP_SCF: flags_next[`FLAG_CARRY] = 1'b1;
            `OP_RCF: flags_next[`FLAG_CARRY] = 1'b0;
            `OP_CCF: flags_next[`FLAG_CARRY] = ~status_flags[`FLAG_CARRY];
            `OP_SDM: flags_next[`FLAG_DATA_SPACE] = 1'b1;
            `OP_SPM: flags_next[`FLAG_DATA_SPACE] = 1'b0;
            default: flags_next = status_flags;
        endcase
        // reserved position is never stored, whatever software writes
        flags_next[`FLAG_RSVD] = 1'b0;
    end

    // ---------------------------------------------------------------
    // saved flag and priority stack
    // ---------------------------------------------------------------
    flag_stack_mem #(
        .WIDTH (11),
        .DEPTH (`STACK_DEPTH),
        .AW    (3)
    ) u_stack (
        .clock   (clock),
        .wr_en   (push),
        .wr_addr (depth_reg),
        .wr_data ({nested_interrupt_control, status_flags}),
        .rd_addr (depth_reg - 3'h1),
        .rd_data (stack_rd)
    );

    // ---------------------------------------------------------------
    // sequential state
    // ---------------------------------------------------------------
    // pop takes two cycles because the stack read is registered
    always @(posedge clock) begin
        if (!reset_n) begin
            status_flags             <= `FLAGS_RESET;
            block_zero               <= 5'h00;
            block_one                <= 5'h00;
            twin_mode_select         <= 1'b0;
            page_reg                 <= 6'h00;
            cpl_reg                  <= `CPL_LOWEST;
            nested_interrupt_control <= `CPL_LOWEST;
            depth_reg                <= 3'h0;
            pop_pending              <= 1'b0;
            int_accept               <= 1'b0;
            stack_overflow           <= 1'b0;
        end else begin
            int_accept     <= preempt;
            stack_overflow <= int_request && (int_level < cpl_reg)
                              && (depth_reg == `STACK_DEPTH);
            pop_pending    <= pop;
            if (push) begin
                nested_interrupt_control <= cpl_reg;
                cpl_reg                  <= int_level;
                depth_reg                <= depth_reg + 3'h1;
                status_flags             <= flags_next;
            end else if (pop) begin
                depth_reg <= depth_reg - 3'h1;
            end else if (pop_pending) begin
                cpl_reg                  <= nested_interrupt_control;
                nested_interrupt_control <= stack_rd[10:8];
                status_flags             <= stack_rd[7:0] & `FLAGS_WRITE_MASK;
            end else if (reg_wr && reg_addr == `ADDR_STATUS_FLAGS) begin
                status_flags <= reg_wdata & `FLAGS_WRITE_MASK;
            end else begin
                status_flags <= flags_next;
            end
            if (reg_wr && reg_addr == `ADDR_CPL_CTRL && !push && !pop_pending) begin
                cpl_reg <= reg_wdata[2:0];
            end
            if (reg_wr && reg_addr == `ADDR_NESTED_CTRL && !push && !pop_pending) begin
                nested_interrupt_control <= reg_wdata[2:0];
            end
            if (set_single_pointer_instr) begin
                block_zero       <= instr_operand[4:0];
                twin_mode_select <= 1'b0;
            end else if (set_low_twin_pointer_instr) begin
                block_zero       <= instr_operand[4:0];
                twin_mode_select <= 1'b1;
            end else if (set_high_twin_pointer_instr) begin
                block_one        <= instr_operand[4:0];
                twin_mode_select <= 1'b1;
            end else if (reg_wr && reg_addr == `ADDR_WPTR_ZERO) begin
                block_zero       <= reg_wdata[`BLOCK_HI:`BLOCK_LO];
                twin_mode_select <= reg_wdata[`TWIN_BIT];
            end else if (reg_wr && reg_addr == `ADDR_WPTR_ONE) begin
                block_one        <= reg_wdata[`BLOCK_HI:`BLOCK_LO];
                twin_mode_select <= reg_wdata[`TWIN_BIT];
            end
            // page pointer is left alone by interrupt entry and return
            if (set_page_instr) begin
                page_reg <= instr_operand[5:0];
            end else if (reg_wr && reg_addr == `ADDR_PAGE_SELECT) begin
                page_reg <= reg_wdata[`PAGE_HI:`PAGE_LO];
            end
        end
    end

    // ---------------------------------------------------------------
    // read port and registered outputs
    // ---------------------------------------------------------------
    reg [7:0] rd_mux;
    reg       rd_err;
    reg [4:0] sel_block;

    always @* begin
        rd_err = 1'b0;
        case (reg_addr)
            `ADDR_STATUS_FLAGS: rd_mux = status_flags;
            `ADDR_WPTR_ZERO:    rd_mux = wptr_zero_view;
            `ADDR_WPTR_ONE:     rd_mux = wptr_one_view;
            `ADDR_PAGE_SELECT:  rd_mux = page_view;
            `ADDR_CPL_CTRL:     rd_mux = {5'h00, cpl_reg};
            `ADDR_NESTED_CTRL:  rd_mux = {5'h00, nested_interrupt_control};
            default: begin
                rd_mux = 8'h00;
                // group d has no direct address
                rd_err = (reg_addr[7:4] == `GROUP_D_HI);
            end
        endcase
        if (twin_mode_select) begin
            sel_block = work_reg_index[3] ? block_one : block_zero;
        end else begin
            sel_block = {block_zero[4:1], work_reg_index[3]};
        end
    end

    always @(posedge clock) begin
        if (!reset_n) begin
            reg_rdata              <= 8'h00;
            reg_addr_err           <= 1'b0;
            work_reg_addr          <= 8'h00;
            page_number            <= 6'h00;
            data_space_select_flag <= 1'b0;
            current_priority       <= `CPL_LOWEST;
        end else begin
            reg_rdata              <= rd_mux;
            reg_addr_err           <= rd_err;
            work_reg_addr          <= {sel_block, work_reg_index[2:0]};
            // page numbers beyond those fitted report page zero
            page_number            <= (page_reg < PAGE_COUNT) ? page_reg : 6'h00;
            data_space_select_flag <= status_flags[`FLAG_DATA_SPACE];
            current_priority       <= cpl_reg;
        end
    end
endmodule // core_sysreg
`default_nettype wire

// *** core_sysreg_regs.vh ***
`ifndef CORE_SYSREG_REGS_VH
`define CORE_SYSREG_REGS_VH
// ---------------------------------------------------------------
// register offsets in the register file
// ---------------------------------------------------------------
`define ADDR_CPL_CTRL        8'he6
`define ADDR_STATUS_FLAGS    8'he7
`define ADDR_WPTR_ZERO       8'he8
`define ADDR_WPTR_ONE        8'he9
`define ADDR_PAGE_SELECT     8'hea
`define ADDR_NESTED_CTRL     8'he1
// ---------------------------------------------------------------
// group boundaries
// ---------------------------------------------------------------
`define GROUP_D_HI           4'hd
`define GROUP_F_HI           4'hf
// ---------------------------------------------------------------
// status flag bit positions
// ---------------------------------------------------------------
`define FLAG_CARRY           7
`define FLAG_ZERO            6
`define FLAG_SIGN            5
`define FLAG_OVERFLOW        4
`define FLAG_BCD_KIND        3
`define FLAG_HALF            2
`define FLAG_RSVD            1
`define FLAG_DATA_SPACE      0
`define FLAGS_RESET          8'h00
`define FLAGS_WRITE_MASK     8'hfd
// ---------------------------------------------------------------
// pointer and page field layout
// ---------------------------------------------------------------
`define BLOCK_HI             7
`define BLOCK_LO             3
`define TWIN_BIT             2
`define PAGE_HI              7
`define PAGE_LO              2
`define CPL_LOWEST           3'h7
`define STACK_DEPTH          7
// ---------------------------------------------------------------
// alu operation codes
// ---------------------------------------------------------------
`define OP_NONE              4'h0
`define OP_ADD               4'h1
`define OP_SUB               4'h2
`define OP_LOGIC             4'h3
`define OP_INCDEC            4'h4
`define OP_SHIFT             4'h5
`define OP_DA                4'h6
`define OP_MULDIV            4'h7
`define OP_SCF               4'h8
`define OP_RCF               4'h9
`define OP_CCF               4'ha
`define OP_SDM               4'hb
`define OP_SPM               4'hc
`endif

// *** core_sysreg_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "core_sysreg_regs.vh"
// ---------------------------------------------------------------
// port checker for the system register block
// ---------------------------------------------------------------
module core_sysreg_chk #(
    parameter PAGE_COUNT = 64
) (
    // clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // register access
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_addr_err,
    // alu and instructions
    input wire logic [3:0]  alu_op,
    input wire logic        alu_word,
    input wire logic [15:0] alu_result,
    input wire logic        set_page_instr,
    input wire logic [7:0]  instr_operand,
    // interrupts and status
    input wire logic        int_request,
    input wire logic [2:0]  int_level,
    input wire logic        int_return,
    input wire logic [5:0]  page_number,
    input wire logic        data_space_select_flag,
    input wire logic [2:0]  current_priority,
    input wire logic        int_accept
);
    // operand is kept so the page check need not look back a variable distance
    reg [5:0] page_cap;
    always @(posedge clock) begin
        if (set_page_instr) begin
            page_cap <= instr_operand[5:0];
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_group_d_error: assert property ((reg_addr[7:4] == `GROUP_D_HI) |=> reg_addr_err)
        else $error("group d address not flagged");
    a_group_d_quiet: assert property ((reg_addr[7:4] != `GROUP_D_HI) |=> !reg_addr_err)
        else $error("address error without group d access");
    a_flag_rsvd_zero: assert property ((reg_addr == `ADDR_STATUS_FLAGS) |=> !reg_rdata[1])
        else $error("reserved flag bit reads one");
    a_ptr_low_zero: assert property ((reg_addr == `ADDR_WPTR_ZERO || reg_addr == `ADDR_WPTR_ONE)
        |=> reg_rdata[1:0] == 2'b00) else $error("pointer low bits not zero");
    a_page_low_zero: assert property ((reg_addr == `ADDR_PAGE_SELECT) |=> reg_rdata[1:0] == 2'b00)
        else $error("page low bits not zero");
    a_set_carry: assert property ((alu_op == `OP_SCF && reg_addr == `ADDR_STATUS_FLAGS && !reg_wr
        && !int_return) ##1 (reg_addr == `ADDR_STATUS_FLAGS && alu_op == `OP_NONE && !reg_wr)
        |=> reg_rdata[`FLAG_CARRY]) else $error("carry not set");
    a_zero_byte: assert property ((alu_op == `OP_ADD && !alu_word && reg_addr == `ADDR_STATUS_FLAGS
        && !reg_wr) ##1 (reg_addr == `ADDR_STATUS_FLAGS && alu_op == `OP_NONE && !reg_wr)
        |=> reg_rdata[`FLAG_ZERO] == ($past(alu_result[7:0], 2) == 8'h00))
        else $error("zero flag wrong");
    a_sign_word: assert property ((alu_op == `OP_ADD && alu_word && reg_addr == `ADDR_STATUS_FLAGS
        && !reg_wr) ##1 (reg_addr == `ADDR_STATUS_FLAGS && alu_op == `OP_NONE && !reg_wr)
        |=> reg_rdata[`FLAG_SIGN] == $past(alu_result[15], 2)) else $error("sign flag wrong");
    a_accept_level: assert property (int_accept |=> current_priority == $past(int_level, 2))
        else $error("priority not taken from accepted request");
    a_no_preempt: assert property ((int_request && int_level >= current_priority) |=> !int_accept)
        else $error("lower or equal level preempted");
    a_page_load: assert property ((set_page_instr && instr_operand[5:0] < PAGE_COUNT && !reg_wr)
        |-> ##[1:2] page_number == page_cap) else $error("page not loaded");
    a_data_space_set: assert property ((alu_op == `OP_SDM) |-> ##[1:2] data_space_select_flag)
        else $error("data space flag not set");
    a_data_space_clr: assert property ((alu_op == `OP_SPM) |-> ##[1:2] !data_space_select_flag)
        else $error("data space flag not cleared");
    c_accept: cover property (int_accept);
    c_group_d: cover property (reg_addr_err);
    c_page: cover property (set_page_instr ##2 page_number == page_cap);
endmodule // core_sysreg_chk
bind core_sysreg core_sysreg_chk #(.PAGE_COUNT(PAGE_COUNT)) chk (.clock(clock), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .reg_addr_err(reg_addr_err),
    .alu_op(alu_op), .alu_word(alu_word), .alu_result(alu_result),
    .set_page_instr(set_page_instr), .instr_operand(instr_operand), .int_request(int_request),
    .int_level(int_level), .int_return(int_return), .page_number(page_number),
    .data_space_select_flag(data_space_select_flag), .current_priority(current_priority),
    .int_accept(int_accept));
`default_nettype wire

// *** flag_stack_mem.v ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// small stack memory for saved flags and priority levels
// ---------------------------------------------------------------
module flag_stack_mem #(
    parameter WIDTH = 11,
    parameter DEPTH = 7,
    parameter AW    = 3
) (
    // clock
    input  wire             clock,
    // write port
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    // read port
    input  wire [AW-1:0]    rd_addr,
    output reg  [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // flag_stack_mem
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "core_sysreg_regs.vh"
module tb_top;
// ---------------------------------------------------------------
// stimulus and observed signals
// ---------------------------------------------------------------
    reg         clock = 1'b0;
    reg         reset_n = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg         reg_wr = 1'b0;
    reg  [7:0]  reg_wdata = 8'h00;
    reg  [3:0]  alu_op = 4'h0;
    reg         alu_word = 1'b0;
    reg  [15:0] alu_a = 16'h0000;
    reg  [15:0] alu_b = 16'h0000;
    reg  [15:0] alu_result = 16'h0000;
    reg         alu_carry = 1'b0;
    reg  [3:0]  instr = 4'h0;
    reg  [7:0]  instr_operand = 8'h00;
    reg         int_request = 1'b0;
    reg  [2:0]  int_level = 3'h0;
    reg         int_return = 1'b0;
    reg  [3:0]  work_reg_index = 4'h0;
    wire [7:0]  reg_rdata;
    wire [7:0]  work_reg_addr;
    wire [5:0]  page_number;
    wire [2:0]  current_priority;
    wire        reg_addr_err;
    wire        data_space_select_flag;
    wire        int_accept, stack_overflow;
    reg  [7:0]  d;
    reg  [1:0]  acc;
    integer     miscompares = 0;
    integer     checked = 0;
    integer     i;
    // instr bits: page, high twin, low twin, single
    core_sysreg uut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_addr_err(reg_addr_err),
        .alu_op(alu_op), .alu_word(alu_word), .alu_a(alu_a), .alu_b(alu_b),
        .alu_result(alu_result), .alu_carry(alu_carry), .set_single_pointer_instr(instr[0]),
        .set_low_twin_pointer_instr(instr[1]), .set_high_twin_pointer_instr(instr[2]),
        .set_page_instr(instr[3]), .instr_operand(instr_operand), .int_request(int_request),
        .int_level(int_level), .int_return(int_return), .work_reg_index(work_reg_index),
        .work_reg_addr(work_reg_addr), .page_number(page_number),
        .data_space_select_flag(data_space_select_flag), .current_priority(current_priority),
        .int_accept(int_accept), .stack_overflow(stack_overflow));
    initial begin
        forever #25 clock = ~clock;
    end
// ---------------------------------------------------------------
// shared tasks
// ---------------------------------------------------------------
    task check(input [7:0] seen, input [7:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("Error at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask
    // address is left in place so flag reads can follow alu steps
    task rd(input [7:0] a);
        begin
            @(posedge clock);
            reg_addr <= a;
            tick(2);
            d = reg_rdata;
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge clock);
            {reg_addr, reg_wr, reg_wdata} <= {a, 1'b1, v};
            @(posedge clock);
            reg_wr <= 1'b0;
        end
    endtask
    task op(input [3:0] o, input w, input [15:0] a, input [15:0] b, input [15:0] r, input c);
        begin
            @(posedge clock);
            {alu_op, alu_word, alu_a, alu_b, alu_result, alu_carry} <= {o, w, a, b, r, c};
            @(posedge clock);
            alu_op <= `OP_NONE;
            rd(`ADDR_STATUS_FLAGS);
        end
    endtask
    task ins(input [3:0] k, input [7:0] v);
        begin
            @(posedge clock);
            {instr, instr_operand} <= {k, v};
            @(posedge clock);
            instr <= 4'h0;
            tick(2);
        end
    endtask
    task wreg(input [3:0] n);
        begin
            @(posedge clock);
            work_reg_index <= n;
            tick(2);
            d = work_reg_addr;
        end
    endtask
    task irq(input [2:0] l);
        begin
            @(posedge clock);
            {int_request, int_level} <= {1'b1, l};
            @(posedge clock);
            int_request <= 1'b0;
            #1 acc = {stack_overflow, int_accept};
            tick(2);
        end
    endtask
    task iret;
        begin
            @(posedge clock);
            int_return <= 1'b1;
            @(posedge clock);
            int_return <= 1'b0;
            tick(3);
        end
    endtask
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
// ---------------------------------------------------------------
// scenarios
// ---------------------------------------------------------------
    task test_reset;
        begin
            rd(`ADDR_STATUS_FLAGS);
            check(d, `FLAGS_RESET);
            check({5'h00, current_priority}, 8'h07);
            wreg(4'h0);
            check(d, 8'h00);
        end
    endtask
    task test_flags;
        begin
            op(`OP_SCF, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
            check(d, 8'h80);
            wr(`ADDR_STATUS_FLAGS, 8'hfd);
            op(`OP_CCF, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
            check(d, 8'h7d);
            wr(`ADDR_STATUS_FLAGS, 8'h00);
            op(`OP_ADD, 1'b0, 16'h00ff, 16'h0001, 16'h0000, 1'b1);
            check(d & 8'hf4, 8'hc4);
            check({7'h00, d[3]}, 8'h00);
            op(`OP_SUB, 1'b0, 16'h0080, 16'h0001, 16'h007f, 1'b0);
            check(d & 8'hf4, 8'h14);
            check({7'h00, d[3]}, 8'h01);
            op(`OP_ADD, 1'b1, 16'h7fff, 16'h0001, 16'h8000, 1'b0);
            check(d & 8'hf0, 8'h30);
            op(`OP_LOGIC, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
            check(d & 8'h60, 8'h40);
            op(`OP_SDM, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
            check({7'h00, data_space_select_flag}, 8'h01);
            op(`OP_SPM, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
            check({6'h00, d[0], data_space_select_flag}, 8'h00);
        end
    endtask
    task test_pointers;
        begin
            ins(4'h1, 8'h03);
            wreg(4'h5);
            check(d, 8'h15);
            wreg(4'hd);
            check(d, 8'h1d);
            rd(`ADDR_WPTR_ZERO);
            check(d & 8'h07, 8'h00);
            ins(4'h2, 8'h04);
            ins(4'h4, 8'h1f);
            wreg(4'h2);
            check(d, 8'h22);
            wreg(4'ha);
            check(d, 8'hfa);
            rd(`ADDR_WPTR_ZERO);
            check(d, 8'h24);
            rd(`ADDR_WPTR_ONE);
            check(d & 8'hf8, 8'hf8);
            wr(`ADDR_WPTR_ZERO, 8'h2f);
            rd(`ADDR_WPTR_ZERO);
            check(d, 8'h2c);
            wreg(4'h1);
            check(d, 8'h29);
        end
    endtask
    task test_page;
        begin
            ins(4'h8, 8'h05);
            check({2'b00, page_number}, 8'h05);
            wr(`ADDR_PAGE_SELECT, 8'hff);
            rd(`ADDR_PAGE_SELECT);
            check(d, 8'hfc);
            check({2'b00, page_number}, 8'h3f);
            rd(8'hd3);
            check({7'h00, reg_addr_err}, 8'h01);
        end
    endtask
    task test_interrupts;
        begin
            op(`OP_SCF, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
            irq(3'h2);
            check({6'h00, acc}, 8'h01);
            check({5'h00, current_priority}, 8'h02);
            rd(`ADDR_NESTED_CTRL);
            check(d & 8'h07, 8'h07);
            irq(3'h3);
            check({6'h00, acc}, 8'h00);
            op(`OP_RCF, 1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
            ins(4'h8, 8'h09);
            iret;
            rd(`ADDR_STATUS_FLAGS);
            check(d & 8'h80, 8'h80);
            check({5'h00, current_priority}, 8'h07);
            check({2'b00, page_number}, 8'h09);
            // seven nested levels is the deepest the flag stack holds
            for (i = 6; i >= 0; i = i - 1) begin
                irq(i[2:0]);
                check({6'h00, acc}, 8'h01);
            end
            wr(`ADDR_CPL_CTRL, 8'h07);
            irq(3'h3);
            check({6'h00, acc}, 8'h02);
            repeat (7) iret;
            check({5'h00, current_priority}, 8'h07);
        end
    endtask
    initial begin
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        test_reset;
        test_flags;
        test_pointers;
        test_page;
        test_interrupts;
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares = miscompares + 1;
        final_report;
    end
endmodule // tb_top
`default_nettype wire
